// ==== rtl/acc_pkg.sv ====
package acc_pkg;

	// ****************************************************************
	// Register offsets.
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL_ZERO   = 8'hdc;
	localparam logic [7:0] OFS_CTRL_ONE    = 8'hdd;
	localparam logic [7:0] OFS_OFFSET_TRIM = 8'he6;
	localparam logic [7:0] OFS_ACLK_DIV    = 8'hf6;
	localparam logic [7:0] OFS_DEC_LOW     = 8'hd2;
	localparam logic [7:0] OFS_DEC_HIGH    = 8'hd3;
	localparam logic [7:0] OFS_MUX_SEL     = 8'hd7;
	localparam logic [7:0] OFS_CUR_DAC     = 8'he8;
	localparam logic [7:0] OFS_STATUS      = 8'hd8;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int CZ_BUF      = 0;
	localparam int CZ_OCS      = 1;
	localparam int CZ_REF_ON   = 2;
	localparam int CZ_REF_HI   = 3;
	localparam int CZ_REF_EXT  = 4;
	localparam int CZ_GAIN_LO  = 5;
	localparam int CO_CAL_LO   = 0;
	localparam int CO_FILT_LO  = 4;
	localparam int ST_IRQ      = 0;
	localparam int ST_CAL_BUSY = 1;

	// ****************************************************************
	// Reset values.
	// ****************************************************************
	localparam logic [7:0] RST_CTRL_ZERO = 8'h0c;
	localparam logic [7:0] RST_CTRL_ONE  = 8'h00;
	localparam logic [7:0] RST_ACLK_DIV  = 8'h00;
	localparam logic [7:0] RST_DEC_LOW   = 8'h80;
	localparam logic [7:0] RST_DEC_HIGH  = 8'h00;
	localparam logic [7:0] RST_MUX_SEL   = 8'h01;

	// ****************************************************************
	// Timing counts and temperature mux code.
	// ****************************************************************
	localparam logic [6:0] MOD_DIVIDE    = 7'h40;
	localparam logic [3:0] CAL_PERIODS   = 4'h7;
	localparam logic [1:0] FAST_CONVS    = 2'h2;
	localparam logic [7:0] MUX_TEMP_SEL  = 8'hff;

	// ****************************************************************
	// Enumerations.
	// ****************************************************************
	typedef enum logic [1:0] {
		ACC_FILT_AUTO,
		ACC_FILT_FAST,
		ACC_FILT_SINC2,
		ACC_FILT_SINC3
	} acc_filt_t;

	typedef enum logic [2:0] {
		ACC_CAL_NONE,
		ACC_CAL_SELF_BOTH,
		ACC_CAL_SELF_OFS,
		ACC_CAL_SELF_GAIN,
		ACC_CAL_SYS_OFS,
		ACC_CAL_SYS_GAIN,
		ACC_CAL_RSV6,
		ACC_CAL_RSV7
	} acc_cal_t;

endpackage

// ==== rtl/acc_regfile.sv ====
`timescale 1ns/1ns
module acc_regfile (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Write port.
	input  wire logic       wr_en,
	input  wire logic [3:0] wr_idx,
	input  wire logic [7:0] wr_data,
	// Read port.
	input  wire logic [3:0] rd_idx,
	output logic      [7:0] rd_data,
	// All words, flattened.
	output logic      [127:0] words
);
	import acc_pkg::*;

	logic [7:0] mem [16];

	// ****************************************************************
	// Storage with registered read.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 16; i++) begin
				mem[i] <= 8'h00;
			end
			mem[0] <= RST_CTRL_ZERO;
			mem[1] <= RST_CTRL_ONE;
			mem[3] <= RST_ACLK_DIV;
			mem[4] <= RST_DEC_LOW;
			mem[5] <= RST_DEC_HIGH;
			mem[6] <= RST_MUX_SEL;
		end else if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem[rd_idx];
		end
	end

	always_comb begin
		for (int i = 0; i < 16; i++) begin
			words[i*8 +: 8] = mem[i];
		end
	end

endmodule

// ==== rtl/acc_top.sv ====
`timescale 1ns/1ns
module acc_top (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// Special function register port.
	input  wire logic [7:0]           sfr_addr,
	input  wire logic [7:0]           sfr_wdata,
	input  wire logic                 sfr_wr,
	input  wire logic                 sfr_rd,
	output logic      [7:0]           sfr_rdata,
	// Analog front-end controls.
	output logic                      buf_en,
	output logic                      ocs_source_en,
	output logic                      ocs_sink_en,
	output logic      [3:0]           mux_pos,
	output logic      [3:0]           mux_neg,
	output logic                      temp_diode_en,
	output logic      [2:0]           gain_sel,
	output logic                      offset_sign,
	output logic      [6:0]           offset_mag,
	output logic                      ref_int_en,
	output logic                      ref_int_high,
	output logic                      ref_ext_sel,
	output logic      [7:0]           current_dac_code,
	// Modulator, filter, calibration and interrupt.
	output logic                      aclk_en,
	output logic                      mod_en,
	output logic                      result_en,
	output logic      [1:0]           filt_active,
	output logic                      cal_busy,
	output logic      [2:0]           cal_active,
	output logic                      conv_irq
);
	import acc_pkg::*;

	logic [127:0] words;
	logic [4:0]   dec;
	logic [3:0]   wr_idx;
	logic [3:0]   rd_idx;
	logic         wr_hit;
	logic [7:0]   cz;
	logic [7:0]   co;
	logic [7:0]   aclk_div;
	logic [15:0]  dec_ratio;
	logic [7:0]   mux_sel;
	logic [7:0]   aclk_q;
	logic [5:0]   mod_cnt;
	logic [15:0]  dec_cnt;
	logic [1:0]   auto_step;
	logic [3:0]   cal_cnt;
	logic         cal_second;
	logic         restart;

	// ****************************************************************
	// Address decode.
	// ****************************************************************
	function automatic logic [4:0] decode(input logic [7:0] a);
		case (a)
			OFS_CTRL_ZERO:   decode = 5'h10;
			OFS_CTRL_ONE:    decode = 5'h11;
			OFS_OFFSET_TRIM: decode = 5'h12;
			OFS_ACLK_DIV:    decode = 5'h13;
			OFS_DEC_LOW:     decode = 5'h14;
			OFS_DEC_HIGH:    decode = 5'h15;
			OFS_MUX_SEL:     decode = 5'h16;
			OFS_CUR_DAC:     decode = 5'h17;
			default:         decode = 5'h00;
		endcase
	endfunction

	function automatic logic cal_last(input logic [3:0] n);
		cal_last = n == CAL_PERIODS - 4'h1;
	endfunction

	function automatic logic cal_code_ok(input logic [2:0] c);
		cal_code_ok = (c != ACC_CAL_NONE) && (c <= ACC_CAL_SYS_GAIN);
	endfunction

	assign dec     = decode(sfr_addr);
	assign wr_hit  = sfr_wr && dec[4];
	assign wr_idx  = dec[3:0];
	assign rd_idx  = dec[3:0];
	assign cz        = words[0*8 +: 8];
	assign co        = words[1*8 +: 8];
	assign aclk_div  = words[3*8 +: 8];
	assign dec_ratio = {words[5*8 +: 8], words[4*8 +: 8]};
	assign mux_sel   = words[6*8 +: 8];
	assign restart   = sfr_wr && (sfr_addr == OFS_MUX_SEL || sfr_addr == OFS_CTRL_ZERO);

	// ****************************************************************
	// Register storage.
	// ****************************************************************
	acc_regfile u_regs (
		.clk     (clk),
		.rst_b   (rst_b),
		.wr_en   (wr_hit),
		.wr_idx  (wr_idx),
		.wr_data (sfr_wdata),
		.rd_idx  (rd_idx),
		.rd_data (),
		.words   (words)
	);

	// ****************************************************************
	// Register read-back.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			if (sfr_addr == OFS_STATUS) begin
				sfr_rdata <= {6'h00, cal_busy, conv_irq};
			end else if (dec[4]) begin
				sfr_rdata <= words[{dec[3:0], 3'h0} +: 8];
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end

	// ****************************************************************
	// Front-end control outputs.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			buf_en           <= RST_CTRL_ZERO[CZ_BUF];
			ocs_source_en    <= RST_CTRL_ZERO[CZ_OCS];
			ocs_sink_en      <= RST_CTRL_ZERO[CZ_OCS];
			mux_pos          <= RST_MUX_SEL[7:4];
			mux_neg          <= RST_MUX_SEL[3:0];
			temp_diode_en    <= 1'b0;
			gain_sel         <= RST_CTRL_ZERO[CZ_GAIN_LO +: 3];
			offset_sign      <= 1'b0;
			offset_mag       <= 7'h00;
			ref_int_en       <= RST_CTRL_ZERO[CZ_REF_ON];
			ref_int_high     <= RST_CTRL_ZERO[CZ_REF_HI];
			ref_ext_sel      <= RST_CTRL_ZERO[CZ_REF_EXT];
			current_dac_code <= 8'h00;
		end else begin
			buf_en           <= cz[CZ_BUF];
			ocs_source_en    <= cz[CZ_OCS];
			ocs_sink_en      <= cz[CZ_OCS];
			temp_diode_en    <= mux_sel == MUX_TEMP_SEL;
			mux_pos          <= (mux_sel == MUX_TEMP_SEL) ? 4'hf : mux_sel[7:4];
			mux_neg          <= (mux_sel == MUX_TEMP_SEL) ? 4'hf : mux_sel[3:0];
			gain_sel         <= cz[CZ_GAIN_LO +: 3];
			offset_sign      <= words[2*8 + 7];
			offset_mag       <= words[2*8 +: 7];
			ref_int_en       <= cz[CZ_REF_ON];
			ref_int_high     <= cz[CZ_REF_HI];
			ref_ext_sel      <= cz[CZ_REF_EXT];
			current_dac_code <= words[7*8 +: 8];
		end
	end

	// ****************************************************************
	// Clock dividers.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			aclk_q  <= 8'h00;
			aclk_en <= 1'b0;
		end else if (aclk_q >= aclk_div) begin
			aclk_q  <= 8'h00;
			aclk_en <= 1'b1;
		end else begin
			aclk_q  <= aclk_q + 8'h01;
			aclk_en <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mod_cnt <= 6'h00;
			mod_en  <= 1'b0;
		end else begin
			mod_en <= 1'b0;
			if (aclk_en) begin
				if (mod_cnt == 6'(MOD_DIVIDE - 7'h01)) begin
					mod_cnt <= 6'h00;
					mod_en  <= 1'b1;
				end else begin
					mod_cnt <= mod_cnt + 6'h01;
				end
			end
		end
	end

	// ****************************************************************
	// Decimation, filter and calibration.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dec_cnt   <= 16'h0000;
			result_en <= 1'b0;
		end else begin
			result_en <= 1'b0;
			if (restart) begin
				dec_cnt <= 16'h0000;
			end else if (mod_en) begin
				if (dec_cnt + 16'h0001 >= dec_ratio) begin
					dec_cnt   <= 16'h0000;
					result_en <= 1'b1;
				end else begin
					dec_cnt <= dec_cnt + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			auto_step   <= 2'h0;
			filt_active <= ACC_FILT_FAST;
		end else begin
			if (restart) begin
				auto_step <= 2'h0;
			end else if (result_en && auto_step != 2'h3) begin
				auto_step <= auto_step + 2'h1;
			end
			case (acc_filt_t'(co[CO_FILT_LO +: 2]))
				ACC_FILT_AUTO: begin
					if (auto_step < FAST_CONVS) begin
						filt_active <= ACC_FILT_FAST;
					end else if (auto_step == FAST_CONVS) begin
						filt_active <= ACC_FILT_SINC2;
					end else begin
						filt_active <= ACC_FILT_SINC3;
					end
				end
				default: filt_active <= co[CO_FILT_LO +: 2];
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cal_busy   <= 1'b0;
			cal_active <= 3'h0;
			cal_cnt    <= 4'h0;
			cal_second <= 1'b0;
		end else if (!cal_busy) begin
			if (sfr_wr && sfr_addr == OFS_CTRL_ONE && cal_code_ok(sfr_wdata[CO_CAL_LO +: 3])) begin
				cal_busy   <= 1'b1;
				cal_active <= sfr_wdata[CO_CAL_LO +: 3];
				cal_cnt    <= 4'h0;
				cal_second <= sfr_wdata[CO_CAL_LO +: 3] == ACC_CAL_SELF_BOTH;
			end
		end else if (result_en) begin
			if (cal_last(cal_cnt)) begin
				cal_cnt <= 4'h0;
				if (cal_second) begin
					cal_second <= 1'b0;
				end else begin
					cal_busy   <= 1'b0;
					cal_active <= 3'h0;
				end
			end else begin
				cal_cnt <= cal_cnt + 4'h1;
			end
		end
	end

	// ****************************************************************
	// Converter interrupt flag; a set wins over a status read clear.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			conv_irq <= 1'b0;
		end else if (result_en && (cal_busy ? (cal_last(cal_cnt) && !cal_second) : 1'b1)) begin
			conv_irq <= 1'b1;
		end else if (sfr_rd && sfr_addr == OFS_STATUS) begin
			conv_irq <= 1'b0;
		end
	end

endmodule

// ==== testbench/acc_front_model.sv ====
`timescale 1ns/1ns
// ****************
// Front-end model.
// ****************
module acc_front_model
	import acc_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Converter state.
	input  wire logic        cal_busy,
	input  wire logic [2:0]  cal_active,
	input  wire logic        result_en,
	// Model outputs.
	output logic             full_scale,
	output logic      [15:0] result_cnt
);
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			result_cnt <= 16'h0000;
		end else if (result_en) begin
			result_cnt <= result_cnt + 16'h0001;
		end
	end
	// Full scale during system gain calibration, zero input otherwise.
	assign full_scale = cal_busy && cal_active == ACC_CAL_SYS_GAIN;
endmodule

// ==== testbench/acc_top_asserts.sv ====
`timescale 1ns/1ns
// ********
// Checker.
// ********
module acc_top_asserts
	import acc_pkg::*;
(
	// Clock and reset.
	input wire logic       clk,
	input wire logic       rst_b,
	// Register port.
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	// Outputs.
	input wire logic       buf_en,
	input wire logic       ocs_source_en,
	input wire logic       ocs_sink_en,
	input wire logic [3:0] mux_pos,
	input wire logic       temp_diode_en,
	input wire logic [2:0] gain_sel,
	input wire logic       offset_sign,
	input wire logic [6:0] offset_mag,
	input wire logic       ref_int_en,
	input wire logic       ref_int_high,
	input wire logic       ref_ext_sel,
	input wire logic [7:0] current_dac_code,
	input wire logic       cal_busy,
	input wire logic       conv_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence wr_s(logic [7:0] a);
		sfr_wr && sfr_addr == a;
	endsequence
	ref_reset_a:
	assert property (disable iff (1'b0) !rst_b |=> ref_int_en && ref_int_high) else $error("reference not default");
	buf_follow_a:
	assert property (wr_s(OFS_CTRL_ZERO) |-> ##2 buf_en == $past(sfr_wdata[0], 2)) else $error("buffer wrong");
	gain_follow_a:
	assert property (wr_s(OFS_CTRL_ZERO) |-> ##2 gain_sel == $past(sfr_wdata[7:5], 2)) else $error("gain wrong");
	ref_select_a:
	assert property (wr_s(OFS_CTRL_ZERO) |-> ##2 {ref_ext_sel, ref_int_high} == $past(sfr_wdata[4:3], 2))
		else $error("reference select wrong");
	offset_sign_a:
	assert property (wr_s(OFS_OFFSET_TRIM) |-> ##2 {offset_sign, offset_mag} == $past(sfr_wdata, 2))
		else $error("offset trim wrong");
	current_dac_code_code_a:
	assert property (wr_s(OFS_CUR_DAC) |-> ##2 current_dac_code == $past(sfr_wdata, 2)) else $error("current_dac_code wrong");
	temp_diode_a:
	assert property (wr_s(OFS_MUX_SEL) && sfr_wdata == MUX_TEMP_SEL |-> ##2 temp_diode_en && mux_pos == 4'hf)
		else $error("temperature diodes not selected");
	ocs_pair_a:
	assert property (wr_s(OFS_CTRL_ZERO) |-> ##2 ocs_source_en == $past(sfr_wdata[1], 2) && ocs_sink_en == ocs_source_en)
		else $error("open circuit currents wrong");
	cal_start_a:
	assert property (wr_s(OFS_CTRL_ONE) && sfr_wdata[2:0] inside {[1:5]} && !cal_busy |-> ##[1:3] cal_busy)
		else $error("calibration did not start");
	cal_irq_a:
	assert property ($fell(cal_busy) |-> ##[0:2] conv_irq) else $error("no flag after calibration");
endmodule
bind acc_top acc_top_asserts u_acc_top_asserts (.clk, .rst_b, .sfr_addr, .sfr_wdata, .sfr_wr, .buf_en,
	.ocs_source_en, .ocs_sink_en, .mux_pos, .temp_diode_en, .gain_sel, .offset_sign, .offset_mag,
	.ref_int_en, .ref_int_high, .ref_ext_sel, .current_dac_code, .cal_busy, .conv_irq);

// ==== testbench/test_acc_top.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch at %0t got %h exp %h", $time, (a), (b)); end end
module test_acc_top;
	import acc_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d;} acc_row_t;
	logic        clk, rst_b, sfr_wr, sfr_rd, buf_en, ocs_source_en, ocs_sink_en, temp_diode_en;
	logic        offset_sign, ref_int_en, ref_int_high, ref_ext_sel, aclk_en, mod_en, result_en;
	logic        cal_busy, conv_irq, full_scale;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, current_dac_code, v;
	logic [3:0]  mux_pos, mux_neg;
	logic [2:0]  gain_sel, cal_active;
	logic [6:0]  offset_mag;
	logic [1:0]  filt_active;
	logic [15:0] result_cnt;
	int          err_count, compares, n, k;
	acc_row_t    rows [11] = '{'{OFS_CTRL_ZERO, 8'h0d}, '{OFS_CTRL_ZERO, 8'he2}, '{OFS_CTRL_ZERO, 8'h18},
		'{OFS_CTRL_ZERO, 8'h44}, '{OFS_OFFSET_TRIM, 8'h85}, '{OFS_OFFSET_TRIM, 8'h7f}, '{OFS_CUR_DAC, 8'hff},
		'{OFS_CUR_DAC, 8'h01}, '{OFS_MUX_SEL, 8'h23}, '{OFS_MUX_SEL, 8'h32}, '{OFS_MUX_SEL, 8'hff}};
	acc_top u_acc_top (.clk, .rst_b, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .buf_en, .ocs_source_en,
		.ocs_sink_en, .mux_pos, .mux_neg, .temp_diode_en, .gain_sel, .offset_sign, .offset_mag, .ref_int_en,
		.ref_int_high, .ref_ext_sel, .current_dac_code, .aclk_en, .mod_en, .result_en, .filt_active, .cal_busy,
		.cal_active, .conv_irq);
	acc_front_model u_acc_front_model (.clk, .rst_b, .cal_busy, .cal_active, .result_en, .full_scale, .result_cnt);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 d = sfr_rdata;
	endtask
	task automatic pulse(input int r, output int c);
		c = 0;
		do begin tick(); c++; end while ((r == 2 ? aclk_en : (r == 1 ? result_en : mod_en)) !== 1'b1 && c < 20000);
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	function automatic logic [7:0] view(input logic [7:0] a);
		case (a)
			OFS_CTRL_ZERO:   view = {gain_sel, ref_ext_sel, ref_int_high, ref_int_en, ocs_source_en, buf_en};
			OFS_OFFSET_TRIM: view = {offset_sign, offset_mag};
			OFS_CUR_DAC:     view = current_dac_code;
			default:         view = {mux_pos, mux_neg};
		endcase
	endfunction
	task automatic results();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#(40 * 60000);
		err_count++;
		results();
	end
	initial begin
		{rst_b, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		tick();
		`CHK({ref_int_en, ref_int_high, ref_ext_sel}, 3'h6)
		rd(8'h00, v);
		`CHK(v, 8'h00)
		rd(OFS_CTRL_ZERO, v);
		`CHK(v, RST_CTRL_ZERO)
		done("reset");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			repeat (2) tick();
			`CHK(view(rows[i].a), rows[i].d)
			if (rows[i].a == OFS_CTRL_ZERO) `CHK(ocs_sink_en, rows[i].d[CZ_OCS])
			rd(rows[i].a, v);
			`CHK(v, rows[i].d)
		end
		done("rows");
		wr(OFS_ACLK_DIV, 8'h02);
		pulse(2, n);
		pulse(2, n);
		`CHK(n, 3)
		pulse(0, n);
		pulse(0, n);
		`CHK(n, 3 * 64)
		wr(OFS_ACLK_DIV, 8'h00);
		wr(OFS_DEC_HIGH, 8'h00);
		wr(OFS_DEC_LOW, 8'h04);
		wr(OFS_MUX_SEL, 8'h01);
		pulse(1, n);
		pulse(1, n);
		`CHK(n, 4 * 64)
		done("rates");
		for (int f = 1; f < 4; f++) begin
			wr(OFS_CTRL_ONE, 8'(f << 4));
			repeat (2) tick();
			`CHK(filt_active, 2'(f))
		end
		wr(OFS_CTRL_ONE, 8'h00);
		for (int j = 0; j < 2; j++) begin
			wr(j ? OFS_CTRL_ZERO : OFS_MUX_SEL, j ? 8'h2c : 8'h45);
			for (int c = 0; c < 4; c++) begin
				pulse(1, n);
				`CHK(filt_active, (c < 2) ? 2'h1 : 2'(c))
			end
		end
		done("filter");
		rd(OFS_STATUS, v);
		k = int'(result_cnt);
		pulse(1, n);
		repeat (2) tick();
		rd(OFS_STATUS, v);
		`CHK(v[ST_IRQ], 1'b1)
		`CHK(int'(result_cnt), k + 1)
		done("flag");
		for (int c = 1; c < 6; c++) begin
			wr(OFS_MUX_SEL, 8'h01);
			wr(OFS_OFFSET_TRIM, 8'h00);
			rd(OFS_STATUS, v);
			wr(OFS_CTRL_ONE, 8'(c));
			k = 0;
			while (cal_busy !== 1'b1 && k < 8) begin tick(); k++; end
			`CHK(cal_active, 3'(c))
			`CHK(full_scale, 1'(c == 5))
			if (c == 1) wr(OFS_CTRL_ONE, 8'h03);
			n = 0;
			while (cal_busy === 1'b1 && k < 20000) begin n += int'(result_en === 1'b1); tick(); k++; end
			`CHK(n, (c == 1) ? 14 : 7)
			rd(OFS_STATUS, v);
			`CHK(v[ST_IRQ], 1'b1)
		end
		wr(OFS_CTRL_ONE, 8'h06);
		repeat (2) tick();
		`CHK(cal_busy, 1'b0)
		done("calibration");
		results();
	end
endmodule
